// file: common/sptbg_defs.vh
// Register offsets, field positions, reset values and timing constants for the serial port
`ifndef SPTBG_DEFS_VH
`define SPTBG_DEFS_VH
`define SPTBG_ADR_DATA        8'h00
`define SPTBG_ADR_SCTRL       8'h04
`define SPTBG_ADR_RATE        8'h08
`define SPTBG_ADR_ACTRL       8'h0C
`define SPTBG_ADR_RELOAD_LO   8'h10
`define SPTBG_ADR_RELOAD_HI   8'h14
`define SPTBG_ADR_COUNT_LO    8'h18
`define SPTBG_ADR_COUNT_HI    8'h1C
`define SPTBG_SCTRL_RST       8'h00
`define SPTBG_ACTRL_RST       8'h00
`define SPTBG_RATE_RST        8'h00
`define SPTBG_SC_RXDONE       0
`define SPTBG_SC_TXDONE       1
`define SPTBG_SC_RX9          2
`define SPTBG_SC_TX9          3
`define SPTBG_SC_RXEN         4
`define SPTBG_SC_FILT         5
`define SPTBG_SC_MLOW         6
`define SPTBG_SC_MHIGH        7
`define SPTBG_AC_CSRC         1
`define SPTBG_AC_RUN          2
`define SPTBG_AC_EXTEN        3
`define SPTBG_AC_TXSRC        4
`define SPTBG_AC_RXSRC        5
`define SPTBG_AC_EXTFLAG      6
`define SPTBG_AC_OVF          7
`define SPTBG_RT_DOUBLE       0
`define SPTBG_RT_SIXCLK       1
`define SPTBG_OVS             16
`define SPTBG_LEN_SHIFT       4'h8
`define SPTBG_LEN_8BIT        4'hA
`define SPTBG_LEN_9BIT        4'hB
`endif

// file: logic/sptbg_serial_port.v
// Full-duplex serial port with auxiliary baud generator timer and Wishbone registers
`timescale 1ns/1ps
`include "sptbg_defs.vh"
module sptbg_serial_port #(
   parameter PRI_DIV = 16'd26
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        serial_rx_line_i,
   output reg         serial_rx_line_o,
   output reg         serial_rx_line_oe_n_o,
   output reg         serial_tx_line_o,
   input  wire        ext_trigger_pin_i,
   input  wire        ext_count_pin_i
);
   // Mode 0 rx line drive: oe low while driving
   reg [7:0]  sctrl_ff;
   reg [7:0]  actrl_ff;
   reg [1:0]  rate_ff;
   reg [7:0]  reload_lo_ff;
   reg [7:0]  reload_hi_ff;
   reg [15:0] count_ff;
   reg [7:0]  rx_buf_ff;
   reg [2:0]  rxs_ff;
   reg [2:0]  trg_ff;
   reg [2:0]  cnt_ff;
   reg        half_ff;
   reg [15:0] pri_cnt_ff;
   reg        pri_half_ff;
   reg [4:0]  m2_cnt_ff;
   reg        trg_lvl_ff;
   reg        cnt_lvl_ff;
   reg        rxs_lvl_ff;
   // Transmitter
   reg        tx_busy_ff;
   reg [10:0] tx_sh_ff;
   reg [3:0]  tx_bits_ff;
   reg [3:0]  tx_ph_ff;
   // Receiver
   reg        rx_busy_ff;
   reg [3:0]  rx_ph_ff;
   reg [3:0]  rx_bits_ff;
   reg [9:0]  rx_sh_ff;
   reg        m0_clk_ff;

   wire [1:0] mode    = {sctrl_ff[`SPTBG_SC_MHIGH], sctrl_ff[`SPTBG_SC_MLOW]};
   wire       six_clk = rate_ff[`SPTBG_RT_SIXCLK];
   wire       dbl     = rate_ff[`SPTBG_RT_DOUBLE];
   wire       bg_mode = actrl_ff[`SPTBG_AC_TXSRC] | actrl_ff[`SPTBG_AC_RXSRC];
   wire       wb_go   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wr      = wb_go & wb_we_i & wb_sel_i[0];
   wire [7:0] wd      = wb_dat_i[7:0];

   // Frame modes as carried in the two mode bits
   localparam [1:0] MODE_SHIFT = 2'h0;
   localparam [1:0] MODE_8BIT  = 2'h1;
   localparam [1:0] MODE_9FIX  = 2'h2;

   // Frame length in bit times; shared by both directions
   function [3:0] frame_len_f;
      input [1:0] md;
      begin
         case (md)
            MODE_SHIFT: frame_len_f = `SPTBG_LEN_SHIFT;
            MODE_8BIT:  frame_len_f = `SPTBG_LEN_8BIT;
            default:    frame_len_f = `SPTBG_LEN_9BIT;
         endcase
      end
   endfunction

   // Mode 2 sample spacing less one: 4 clocks at osc/64, 2 at osc/32, 1 at osc/16
   function [4:0] m2_reload_f;
      input six;
      input dbl_in;
      begin
         case ({six, dbl_in})
            2'b00:   m2_reload_f = 5'h03;
            2'b11:   m2_reload_f = 5'h00;
            default: m2_reload_f = 5'h01;
         endcase
      end
   endfunction

   // Write strobe for one register offset
   // Ack is still low here, so a write lands once per request
   function wr_hit_f;
      input [7:0] adr;
      begin
         wr_hit_f = wr & (wb_adr_i == adr);
      end
   endfunction

   // Read mux; unmapped offsets read zero
   function [31:0] rd_mux_f;
      input [7:0] adr;
      begin
         rd_mux_f = 32'h0000_0000;
         case (adr)
            `SPTBG_ADR_DATA:      rd_mux_f[7:0] = rx_buf_ff;
            `SPTBG_ADR_SCTRL:     rd_mux_f[7:0] = sctrl_ff;
            `SPTBG_ADR_RATE:      rd_mux_f[1:0] = rate_ff;
            `SPTBG_ADR_ACTRL:     rd_mux_f[7:0] = actrl_ff;
            `SPTBG_ADR_RELOAD_LO: rd_mux_f[7:0] = reload_lo_ff;
            `SPTBG_ADR_RELOAD_HI: rd_mux_f[7:0] = reload_hi_ff;
            `SPTBG_ADR_COUNT_LO:  rd_mux_f[7:0] = count_ff[7:0];
            `SPTBG_ADR_COUNT_HI:  rd_mux_f[7:0] = count_ff[15:8];
            default:              rd_mux_f = 32'h0000_0000;
         endcase
      end
   endfunction

   // Pin filters: change counts once stages two and three agree
   always @(posedge clk_i) begin
      if (rst_i) begin
         rxs_ff     <= 3'b111;
         trg_ff     <= 3'b111;
         cnt_ff     <= 3'b111;
         rxs_lvl_ff <= 1'b1;
         trg_lvl_ff <= 1'b1;
         cnt_lvl_ff <= 1'b1;
      end else begin
         rxs_ff <= {rxs_ff[1:0], serial_rx_line_i};
         trg_ff <= {trg_ff[1:0], ext_trigger_pin_i};
         cnt_ff <= {cnt_ff[1:0], ext_count_pin_i};
         if (rxs_ff[1] == rxs_ff[2]) begin
            rxs_lvl_ff <= rxs_ff[2];
         end
         if (trg_ff[1] == trg_ff[2]) begin
            trg_lvl_ff <= trg_ff[2];
         end
         if (cnt_ff[1] == cnt_ff[2]) begin
            cnt_lvl_ff <= cnt_ff[2];
         end
      end
   end
   wire trg_fall = trg_lvl_ff & ~trg_ff[2] & (trg_ff[1] == trg_ff[2]);
   wire cnt_fall = cnt_lvl_ff & ~cnt_ff[2] & (cnt_ff[1] == cnt_ff[2]);
   wire rx_fall  = rxs_lvl_ff & ~rxs_ff[2] & (rxs_ff[1] == rxs_ff[2]);

   // Internal tick: every clk in 6-clock, every other clk in 12-clock
   wire int_tick = six_clk | half_ff;
   wire aux_inc  = actrl_ff[`SPTBG_AC_RUN] &
                   (actrl_ff[`SPTBG_AC_CSRC] ? cnt_fall : int_tick);
   wire aux_ovf  = aux_inc & (count_ff == 16'hFFFF);
   // Primary timer stand-in: fixed divider; n is 32 in 12-clock without double, 16 with double or in 6-clock
   // Six-clock with double would need two ticks per overflow; not supported
   wire pri_ovf  = (pri_cnt_ff == 16'h0000);
   wire pri_tick = pri_ovf & (dbl | six_clk | pri_half_ff);
   wire tx_tick  = actrl_ff[`SPTBG_AC_TXSRC] ? aux_ovf : pri_tick;
   wire rx_tick  = actrl_ff[`SPTBG_AC_RXSRC] ? aux_ovf : pri_tick;
   // Mode 2 sample tick: 16 per bit; osc/64 uses every 4th clk (12-clock)
   wire [4:0] m2_div = m2_reload_f(six_clk, dbl);
   wire m2_tick  = (m2_cnt_ff == 5'h00) | (m2_div == 5'h00);
   wire tx_samp  = (mode == MODE_9FIX) ? m2_tick : tx_tick;
   wire rx_samp  = (mode == MODE_9FIX) ? m2_tick : rx_tick;
   // Mode 0: one bit per 12 (or 6) clocks, phase counter shared
   wire [3:0] m0_len = six_clk ? 4'd5 : 4'd11;
   reg  [3:0] m0_ph_ff;
   wire m0_bit  = (m0_ph_ff == m0_len);
   wire m0_mid  = (m0_ph_ff == {1'b0, m0_len[3:1]});

   always @(posedge clk_i) begin
      if (rst_i) begin
         half_ff     <= 1'b0;
         pri_cnt_ff  <= 16'h0000;
         pri_half_ff <= 1'b0;
         m2_cnt_ff   <= 5'h00;
         m0_ph_ff    <= 4'h0;
      end else begin
         half_ff <= ~half_ff;
         pri_cnt_ff <= pri_ovf ? PRI_DIV : pri_cnt_ff - 16'h0001;
         if (pri_ovf) begin
            pri_half_ff <= ~pri_half_ff;
         end
         m2_cnt_ff <= m2_tick ? m2_div : m2_cnt_ff - 5'h01;
         m0_ph_ff  <= m0_bit ? 4'h0 : m0_ph_ff + 4'h1;
      end
   end

   // Auxiliary timer in baud-generator use
   always @(posedge clk_i) begin
      if (rst_i) begin
         count_ff <= 16'h0000;
      end else if (wr_hit_f(`SPTBG_ADR_COUNT_LO)) begin
         count_ff[7:0] <= wd;
      end else if (wr_hit_f(`SPTBG_ADR_COUNT_HI)) begin
         count_ff[15:8] <= wd;
      end else if (aux_ovf && bg_mode) begin
         count_ff <= {reload_hi_ff, reload_lo_ff};
      end else if (aux_inc) begin
         count_ff <= count_ff + 16'h0001;
      end
   end

   // Transmitter: frames per mode, 16 sample ticks per bit in modes 1-3
   wire tx_start = wr_hit_f(`SPTBG_ADR_DATA);
   wire tx_step  = (mode == 2'd0) ? m0_bit : (tx_samp && tx_ph_ff == 4'hF);
   wire [3:0] tx_len = frame_len_f(mode);
   wire tx_end   = tx_busy_ff & tx_step & (tx_bits_ff == tx_len - 4'd1);
   always @(posedge clk_i) begin
      if (rst_i) begin
         tx_busy_ff <= 1'b0;
         tx_sh_ff   <= 11'h7FF;
         tx_bits_ff <= 4'h0;
         tx_ph_ff   <= 4'h0;
      end else if (tx_start) begin
         tx_busy_ff <= 1'b1;
         tx_bits_ff <= 4'h0;
         tx_ph_ff   <= 4'h0;
         if (mode == 2'd0)
            tx_sh_ff <= {3'b111, wd};
         else if (mode == 2'd1)
            tx_sh_ff <= {2'b11, wd, 1'b0};
         else
            tx_sh_ff <= {1'b1, sctrl_ff[`SPTBG_SC_TX9], wd, 1'b0};
      end else if (tx_busy_ff) begin
         if (mode != 2'd0 && tx_samp) tx_ph_ff <= tx_ph_ff + 4'h1;
         if (tx_step) begin
            tx_sh_ff   <= {1'b1, tx_sh_ff[10:1]};
            tx_bits_ff <= tx_bits_ff + 4'h1;
            if (tx_end) tx_busy_ff <= 1'b0;
         end
      end
   end

   // Receiver: start-bit detect, mid-bit sampling; mode 0 self-clocked
   wire rx_m0_go = (mode == 2'd0) & ~sctrl_ff[`SPTBG_SC_RXDONE] &
                   sctrl_ff[`SPTBG_SC_RXEN] & ~rx_busy_ff & m0_bit;
   wire rx_go    = (mode != 2'd0) & sctrl_ff[`SPTBG_SC_RXEN] & ~rx_busy_ff & rx_fall;
   wire rx_mid   = (mode == 2'd0) ? m0_mid : (rx_samp && rx_ph_ff == 4'h7);
   wire [3:0] rx_len = frame_len_f(mode);
   wire rx_last  = rx_busy_ff & rx_mid & (rx_bits_ff == rx_len - 4'd1);
   wire rx_bad   = rx_busy_ff & rx_mid & (rx_bits_ff == 4'h0) & (mode != 2'd0) & rxs_lvl_ff;
   // Completed frame: data byte and ninth bit as received
   wire [7:0] rx_byte = (mode == 2'd0) ? {rxs_lvl_ff, rx_sh_ff[9:3]} :
                        (mode == 2'd1) ? rx_sh_ff[9:2] : rx_sh_ff[8:1];
   wire rx_nine = (mode == 2'd1) ? rxs_lvl_ff : rx_sh_ff[9];
   // Filter decides whether the frame is accepted
   wire filt    = sctrl_ff[`SPTBG_SC_FILT];
   wire rx_ok   = (mode == 2'd0) ? 1'b1 :
                  (mode == 2'd1) ? (~filt | rxs_lvl_ff) :
                  (~filt | rx_sh_ff[9]);
   // Overrun: unread byte is kept, new byte is lost
   wire rx_load = rx_last & rx_ok & ~sctrl_ff[`SPTBG_SC_RXDONE];
   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_busy_ff <= 1'b0;
         rx_ph_ff   <= 4'h0;
         rx_bits_ff <= 4'h0;
         rx_sh_ff   <= 10'h000;
         rx_buf_ff  <= 8'h00;
      end else if (rx_go || rx_m0_go) begin
         rx_busy_ff <= 1'b1;
         rx_ph_ff   <= 4'h0;
         rx_bits_ff <= 4'h0;
      end else if (rx_busy_ff) begin
         if (mode != 2'd0 && rx_samp) rx_ph_ff <= rx_ph_ff + 4'h1;
         if (rx_mid) begin
            rx_sh_ff   <= {rxs_lvl_ff, rx_sh_ff[9:1]};
            rx_bits_ff <= rx_bits_ff + 4'h1;
         end
         if (rx_last || rx_bad) rx_busy_ff <= 1'b0;
         if (rx_load) rx_buf_ff <= rx_byte;
      end
   end

   // Pins: mode 0 drives data on rx line and shift clock on tx line
   always @(posedge clk_i) begin
      if (rst_i) begin
         serial_tx_line_o      <= 1'b1;
         serial_rx_line_o      <= 1'b1;
         serial_rx_line_oe_n_o <= 1'b1;
         m0_clk_ff             <= 1'b1;
      end else if (mode == 2'd0) begin
         m0_clk_ff             <= ~((tx_busy_ff | rx_busy_ff) & (m0_ph_ff < {1'b0, m0_len[3:1]}));
         serial_tx_line_o      <= m0_clk_ff;
         serial_rx_line_o      <= tx_sh_ff[0];
         serial_rx_line_oe_n_o <= ~tx_busy_ff;
      end else begin
         serial_tx_line_o      <= tx_busy_ff ? tx_sh_ff[0] : 1'b1;
         serial_rx_line_o      <= 1'b1;
         serial_rx_line_oe_n_o <= 1'b1;
      end
   end

   // Register file; hardware sets win over software clears
   always @(posedge clk_i) begin
      if (rst_i) begin
         sctrl_ff     <= `SPTBG_SCTRL_RST;
         actrl_ff     <= `SPTBG_ACTRL_RST;
         rate_ff      <= 2'b00;
         reload_lo_ff <= 8'h00;
         reload_hi_ff <= 8'h00;
      end else begin
         if (wr_hit_f(`SPTBG_ADR_SCTRL)) begin
            sctrl_ff <= wd;
         end
         if (wr_hit_f(`SPTBG_ADR_ACTRL)) begin
            actrl_ff <= wd;
         end
         if (wr_hit_f(`SPTBG_ADR_RATE)) begin
            rate_ff <= wd[1:0];
         end
         // Reload writes while running can collide with a reload
         if (wr_hit_f(`SPTBG_ADR_RELOAD_LO)) begin
            reload_lo_ff <= wd;
         end
         if (wr_hit_f(`SPTBG_ADR_RELOAD_HI)) begin
            reload_hi_ff <= wd;
         end
         if (tx_end) sctrl_ff[`SPTBG_SC_TXDONE] <= 1'b1;
         if (rx_load) begin
            sctrl_ff[`SPTBG_SC_RXDONE] <= 1'b1;
            if (mode != 2'd0) sctrl_ff[`SPTBG_SC_RX9] <= rx_nine;
         end
         // Overflow flag only outside baud-generator use
         if (aux_ovf && !bg_mode) actrl_ff[`SPTBG_AC_OVF] <= 1'b1;
         if (trg_fall && actrl_ff[`SPTBG_AC_EXTEN])
            actrl_ff[`SPTBG_AC_EXTFLAG] <= 1'b1;
      end
   end

   // Wishbone slave: ack one cycle after request, unmapped reads zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_go;
         wb_dat_o <= 32'h0000_0000;
         if (wb_go && !wb_we_i) begin
            wb_dat_o <= rd_mux_f(wb_adr_i);
         end
      end
   end
endmodule

// file: bench/sptbg_serial_port_props.sv
// Port-level assertions for the serial port, bound to its top module
`timescale 1ns/1ps
`include "sptbg_defs.vh"
module sptbg_serial_port_props #(
   parameter PRI_DIV = 16'd26
) (
   input wire        clk_i,
   input wire        rst_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [7:0]  wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        serial_rx_line_i,
   input wire        serial_rx_line_o,
   input wire        serial_rx_line_oe_n_o,
   input wire        serial_tx_line_o,
   input wire        ext_trigger_pin_i,
   input wire        ext_count_pin_i
);
   reg  [1:0] mode_ff;
   wire       take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire       wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   // Shadow of the frame mode; lags the register by at most a cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         mode_ff <= 2'b00;
      end else if (wr_ack && wb_adr_i == `SPTBG_ADR_SCTRL) begin
         mode_ff <= wb_dat_i[7:6];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_follows: assert property (take |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_caused: assert property (wb_ack_o |-> $past(take))
      else $error("ack without request");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i > `SPTBG_ADR_COUNT_HI
      |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_tx_starts: assert property (wr_ack && wb_adr_i == `SPTBG_ADR_DATA && mode_ff != 2'b00
      |-> ##[1:400] !serial_tx_line_o)
      else $error("data write started no frame");
   a_low_hold: assert property ($fell(serial_tx_line_o) && mode_ff != 2'b00
      |-> !serial_tx_line_o [*8])
      else $error("low bit shorter than minimum bit time");
   a_high_hold: assert property ($rose(serial_tx_line_o) && mode_ff != 2'b00
      |-> serial_tx_line_o [*8])
      else $error("high bit shorter than minimum bit time");
   a_drive_mode0: assert property (!serial_rx_line_oe_n_o |-> mode_ff == 2'b00)
      else $error("rx line driven outside shift mode");
   cover property (!serial_rx_line_oe_n_o);
   cover property (wr_ack && wb_adr_i == `SPTBG_ADR_DATA);
   cover property (take && !wb_we_i && wb_adr_i > `SPTBG_ADR_COUNT_HI);
endmodule
bind sptbg_serial_port sptbg_serial_port_props #(.PRI_DIV(PRI_DIV)) sptbg_serial_port_props_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .serial_rx_line_i(serial_rx_line_i), .serial_rx_line_o(serial_rx_line_o),
   .serial_rx_line_oe_n_o(serial_rx_line_oe_n_o), .serial_tx_line_o(serial_tx_line_o),
   .ext_trigger_pin_i(ext_trigger_pin_i), .ext_count_pin_i(ext_count_pin_i));

// file: bench/sptbg_remote.sv
// Remote serial device that sends and captures asynchronous frames
`timescale 1ns/1ps
module sptbg_remote (
   input  wire logic clk_i,
   input  wire logic line_i,
   output logic      line_o
);
   initial line_o = 1'b1;
   // Start bit, then n bits LSB first, the last one being the stop bit
   task automatic send(input int n, input logic [10:0] bits, input int per);
      line_o <= 1'b0;
      repeat (per) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         line_o <= bits[i];
         repeat (per) @(posedge clk_i);
      end
      line_o <= 1'b1;
   endtask
   // Mid-bit sampling, so a wrong bit time garbles the byte
   task automatic recv(input int n, input int per, output logic [10:0] bits);
      int w;
      bits = 11'h000;
      w = 0;
      while (line_i !== 1'b0 && w < 2000) begin
         @(posedge clk_i);
         w++;
      end
      repeat (per / 2) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         repeat (per) @(posedge clk_i);
         bits[i] = line_i;
      end
   endtask
endmodule

// file: bench/sptbg_serial_port_tb.sv
// Self-checking bench for the serial port and its baud generator
`timescale 1ns/1ps
`include "sptbg_defs.vh"
module sptbg_serial_port_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000;
   logic        trig = 1'b1;
   logic [2:0]  cdiv = 3'h0;
   logic [31:0] dat_o;
   logic        ack;
   logic        rx_o;
   logic        oe_n;
   logic        tx_o;
   logic        rem_o;
   logic [31:0] q;
   logic [10:0] b;
   wire         rx_w = oe_n ? rem_o : rx_o;
   int          miscompares = 0;
   int          samples_checked = 0;
   always #50 clk_i = ~clk_i;
   // Count pin runs free, one falling edge every 8 clocks
   always @(posedge clk_i) cdiv <= cdiv + 3'h1;
   sptbg_serial_port #(.PRI_DIV(16'd2)) sptbg_serial_port_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .serial_rx_line_i(rx_w), .serial_rx_line_o(rx_o), .serial_rx_line_oe_n_o(oe_n),
      .serial_tx_line_o(tx_o), .ext_trigger_pin_i(trig), .ext_count_pin_i(cdiv[2]));
   sptbg_remote sptbg_remote_inst (.clk_i(clk_i), .line_i(tx_o), .line_o(rem_o));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 100);
      if (ack !== 1'b1) begin
         $display("[ERR] wb ack expected 1 seen %b", ack);
         miscompares++;
      end
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0000_0000);
      chk(nm, e, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, {24'h00_0000, d});
   endtask
   task automatic txc(input logic [7:0] rt, input logic [7:0] ac, input logic [7:0] sc,
                      input int per, input logic [7:0] d);
      int n;
      logic [10:0] e;
      n = (sc[7:6] == 2'b01) ? 9 : 10;
      e = (n == 9) ? {2'b00, 1'b1, d} : {1'b0, 1'b1, sc[3], d};
      wr(`SPTBG_ADR_RATE, rt);
      wr(`SPTBG_ADR_ACTRL, ac);
      wr(`SPTBG_ADR_SCTRL, sc);
      fork
         sptbg_remote_inst.recv(n, per, b);
         wr(`SPTBG_ADR_DATA, d);
      join
      chk("tx frame", {21'h0, e}, {21'h0, b});
      repeat (per) @(posedge clk_i);
      rc(`SPTBG_ADR_SCTRL, {24'h00_0000, sc | 8'h02}, "tx done");
      $display("tx case %h %h %h done", rt, ac, sc);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rc(`SPTBG_ADR_SCTRL, 32'h0000_0000, "sctrl reset");
      rc(`SPTBG_ADR_ACTRL, 32'h0000_0000, "actrl reset");
      rc(`SPTBG_ADR_RATE, 32'h0000_0000, "rate reset");
      rc(8'h20, 32'h0000_0000, "unmapped");
      wr(`SPTBG_ADR_RELOAD_LO, 8'hFF);
      wr(`SPTBG_ADR_RELOAD_HI, 8'hFF);
      wr(`SPTBG_ADR_COUNT_LO, 8'hFF);
      wr(`SPTBG_ADR_COUNT_HI, 8'hFF);
      txc(8'h00, 8'h34, 8'h40, 32, 8'hA5);
      rc(`SPTBG_ADR_ACTRL, 32'h0000_0034, "no overflow flag");
      txc(8'h02, 8'h34, 8'h40, 16, 8'h5A);
      txc(8'h00, 8'h14, 8'h40, 32, 8'h3C);
      txc(8'h00, 8'h24, 8'h40, 96, 8'hC3);
      txc(8'h01, 8'h00, 8'h40, 48, 8'h96);
      txc(8'h02, 8'h00, 8'h40, 48, 8'h69);
      txc(8'h00, 8'h00, 8'h80, 64, 8'h81);
      txc(8'h01, 8'h00, 8'h88, 32, 8'h7E);
      txc(8'h02, 8'h00, 8'h80, 32, 8'h18);
      txc(8'h03, 8'h00, 8'h80, 16, 8'hE7);
      txc(8'h00, 8'h34, 8'hC8, 32, 8'h4D);
      txc(8'h00, 8'h36, 8'h40, 128, 8'hB2);
      wr(`SPTBG_ADR_ACTRL, 8'h3C);
      trig <= 1'b0;
      repeat (6) @(posedge clk_i);
      rc(`SPTBG_ADR_ACTRL, 32'h0000_007C, "ext trigger flag");
      wr(`SPTBG_ADR_SCTRL, 8'h50);
      sptbg_remote_inst.send(9, 11'h13C, 32);
      repeat (40) @(posedge clk_i);
      rc(`SPTBG_ADR_SCTRL, 32'h0000_0055, "rx mode1");
      fork
         sptbg_remote_inst.send(9, 11'h1C3, 32);
         sptbg_remote_inst.recv(9, 32, b);
         wr(`SPTBG_ADR_DATA, 8'hE1);
      join
      chk("duplex tx", 32'h0000_01E1, {21'h0, b});
      repeat (40) @(posedge clk_i);
      rc(`SPTBG_ADR_DATA, 32'h0000_003C, "overrun keeps first");
      wr(`SPTBG_ADR_SCTRL, 8'hF0);
      sptbg_remote_inst.send(10, 11'h211, 32);
      repeat (40) @(posedge clk_i);
      rc(`SPTBG_ADR_SCTRL, 32'h0000_00F0, "data byte filtered");
      sptbg_remote_inst.send(10, 11'h322, 32);
      repeat (40) @(posedge clk_i);
      rc(`SPTBG_ADR_SCTRL, 32'h0000_00F5, "address byte");
      rc(`SPTBG_ADR_DATA, 32'h0000_0022, "rx data");
      wr(`SPTBG_ADR_SCTRL, 8'h70);
      sptbg_remote_inst.send(9, 11'h055, 32);
      repeat (40) @(posedge clk_i);
      rc(`SPTBG_ADR_SCTRL, 32'h0000_0070, "bad stop filtered");
      $display("rx tests done");
      wr(`SPTBG_ADR_ACTRL, 8'h00);
      wr(`SPTBG_ADR_RELOAD_LO, 8'hFE);
      rc(`SPTBG_ADR_RELOAD_LO, 32'h0000_00FE, "reload low");
      txc(8'h00, 8'h34, 8'h40, 64, 8'h5C);
      wr(`SPTBG_ADR_SCTRL, 8'h00);
      wr(`SPTBG_ADR_DATA, 8'h96);
      repeat (200) @(posedge clk_i);
      rc(`SPTBG_ADR_SCTRL, 32'h0000_0002, "mode0 tx done");
      $display("mode0 test done");
      tally_and_finish();
   end
endmodule
